/* pkg/omc_defs.svh */
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
// boot load time in clock cycles per image; motion image adds a second pass
`define OMC_OTP_LOAD_CYC 16'h0040
`define OMC_MOT_LOAD_CYC 16'h0040
// boot pulse width, ns, and derived cycle count at 4 ns period
`define OMC_PULSE_NS 32'h0000_0190
`define OMC_CLK_NS 32'h0000_0004
`define OMC_PULSE_CYC (((`OMC_PULSE_NS) + (`OMC_CLK_NS) - 1) / (`OMC_CLK_NS))
// measurement cycle length in clock cycles
`define OMC_MEAS_CYC 16'h0020
// sleep delay counter reset value: zero keeps auto wake/sleep off with strap low
`define OMC_SLEEP_DELAY_RST 8'h00
`endif

/* pkg/omc_pkg.sv */
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_OFF,
    OMC_BOOT,
    OMC_STANDBY,
    OMC_HIBERNATE,
    OMC_WAKE,
    OMC_SLEEP,
    OMC_TRIG_WAIT,
    OMC_TRIG_MEAS
  } omc_mode_t;
endpackage : omc_pkg

/* src/omc_pulse_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "omc_defs.svh"
module omc_pulse_timer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire logic start_i,
  input wire logic [15:0] len_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic done;
  } omc_tmr_t;
  omc_tmr_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = len_i;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt <= 16'h0001)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.cnt = 16'h0000;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
endmodule : omc_pulse_timer
`default_nettype wire

/* src/omc_mode_ctrl.sv */
// Contract
// - boot starts at supply good; bus dead below
// - boot loads defaults, then sets boot done
// - strap low: boot pulse, irq a default
// - strap high: also load motion defaults
// - strap high: boot pulse on irq b only
// - hibernate: only wake detector, registers lost
// - strap low: wake pin edge leaves hibernate
// - strap high: motion pin high leaves hibernate
// - standby: sensing off, bus available
// - active: sensing on only when measuring; code keeps it on all through wake, and in sleep while activity is high
// - strap low: nonzero sleep delay enables auto
// - strap high: auto wake/sleep defaults off
// - select set, strap low: trigger edge measures
// - after triggered measure, back to wait
// - active to standby keeps registers
// - strap low: deep-off bit enters hibernate
// - strap high: hibernate while motion pin low
`timescale 1ns/1ps
`default_nettype none
`include "omc_defs.svh"
module omc_mode_ctrl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // supply and strap
  input wire logic supply_good_i,
  input wire logic boot_strap_select_i,
  // pins
  input wire logic wake_cs_i,
  input wire logic motion_wake_pin_i,
  input wire logic trigger_pin_i,
  // host configuration bits
  input wire logic cfg_we_i,
  input wire logic active_req_i,
  input wire logic deep_off_en_i,
  input wire logic trigger_input_select_i,
  input wire logic auto_sleep_en_i,
  input wire logic [7:0] sleep_delay_count_i,
  input wire logic boot_pulse_en_i,
  input wire logic boot_pulse_route_b_i,
  input wire logic activity_i,
  input wire logic boot_done_clr_i,
  // status and outputs
  output logic [2:0] mode_o,
  output logic bus_avail_o,
  output logic sensor_pwr_o,
  output logic wake_det_en_o,
  output logic cfg_reset_o,
  output logic otp_load_o,
  output logic motion_load_o,
  output logic boot_done_flag_o,
  output logic irq_out_a_o,
  output logic irq_out_b_o,
  output logic auto_ws_en_o
);
  typedef struct packed {
    omc_pkg::omc_mode_t mode;
    logic strap;
    logic strap_ok;
    logic mot_phase;
    logic boot_done;
    logic pulse_en;
    logic pulse_b;
    logic trig_sel;
    logic auto_en;
    logic [7:0] sleep_cnt;
    logic [7:0] idle_cnt;
    logic wake_prev;
    logic trig_prev;
    logic bus_avail;
    logic sensor_pwr;
    logic wake_det;
    logic cfg_reset;
    logic otp_load;
    logic motion_load;
    logic irq_a;
    logic irq_b;
    logic auto_ws;
  } omc_state_t;
  localparam logic [15:0] PULSE_CYC = 16'(`OMC_PULSE_CYC);
  omc_state_t s_q, s_d;
  logic tmr_start;
  logic [15:0] tmr_len;
  logic tmr_busy;
  logic tmr_done;
  logic pulse_start;
  logic pulse_busy;
  logic pulse_done;
  function automatic logic is_active(input omc_pkg::omc_mode_t m);
    is_active = (m == omc_pkg::OMC_WAKE) || (m == omc_pkg::OMC_SLEEP) ||
                (m == omc_pkg::OMC_TRIG_WAIT) || (m == omc_pkg::OMC_TRIG_MEAS);
  endfunction : is_active
  omc_pulse_timer u_load_tmr (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(tmr_start),
    .len_i(tmr_len),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );
  omc_pulse_timer u_pulse_tmr (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(pulse_start),
    .len_i(PULSE_CYC),
    .busy_o(pulse_busy),
    .done_o(pulse_done)
  );
  always_comb
  begin
    s_d = s_q;
    tmr_start = 1'b0;
    tmr_len = `OMC_OTP_LOAD_CYC;
    pulse_start = 1'b0;
    s_d.wake_prev = wake_cs_i;
    s_d.trig_prev = trigger_pin_i;
    s_d.cfg_reset = 1'b0;
    // strap captured once after supply is good, re-sampled only after a supply loss or reset
    if (!s_q.strap_ok && supply_good_i)
    begin
      s_d.strap = boot_strap_select_i;
      s_d.strap_ok = 1'b1;
    end
    // host bits latch only while the bus is up
    if (cfg_we_i && s_q.bus_avail)
    begin
      s_d.pulse_en = boot_pulse_en_i;
      s_d.pulse_b = boot_pulse_route_b_i;
      s_d.trig_sel = trigger_input_select_i && !s_q.strap;
      s_d.auto_en = auto_sleep_en_i;
      s_d.sleep_cnt = sleep_delay_count_i;
    end
    // set wins over clear
    if (boot_done_clr_i && s_q.bus_avail)
      s_d.boot_done = 1'b0;
    if (pulse_done)
    begin
      s_d.irq_a = 1'b0;
      s_d.irq_b = 1'b0;
    end
    unique case (s_q.mode)
      omc_pkg::OMC_OFF:
      begin
        if (supply_good_i)
        begin
          s_d.mode = omc_pkg::OMC_BOOT;
          s_d.cfg_reset = 1'b1;
          s_d.otp_load = 1'b1;
          s_d.mot_phase = 1'b0;
          tmr_start = 1'b1;
        end
      end
      omc_pkg::OMC_BOOT:
      begin
        if (tmr_done)
        begin
          if (s_q.strap && !s_q.mot_phase)
          begin
            s_d.otp_load = 1'b0;
            s_d.motion_load = 1'b1;
            s_d.mot_phase = 1'b1;
            tmr_start = 1'b1;
            tmr_len = `OMC_MOT_LOAD_CYC;
          end
          else
          begin
            s_d.otp_load = 1'b0;
            s_d.motion_load = 1'b0;
            s_d.boot_done = 1'b1;
            s_d.bus_avail = 1'b1;
            if (s_q.strap)
            begin
              // strap high boots straight into motion wake
              s_d.mode = omc_pkg::OMC_WAKE;
              s_d.irq_b = 1'b1;
              pulse_start = 1'b1;
            end
            else
            begin
              s_d.mode = omc_pkg::OMC_STANDBY;
              if (s_q.pulse_en)
              begin
                s_d.irq_a = !s_q.pulse_b;
                s_d.irq_b = s_q.pulse_b;
                pulse_start = 1'b1;
              end
            end
          end
        end
      end
      omc_pkg::OMC_STANDBY:
      begin
        s_d.sensor_pwr = 1'b0;
        if (!s_q.strap && deep_off_en_i && cfg_we_i)
          s_d.mode = omc_pkg::OMC_HIBERNATE;
        else if (s_q.strap && !motion_wake_pin_i)
          s_d.mode = omc_pkg::OMC_HIBERNATE;
        else if (s_q.trig_sel && !s_q.strap)
          s_d.mode = omc_pkg::OMC_TRIG_WAIT;
        else if (active_req_i && cfg_we_i)
          s_d.mode = omc_pkg::OMC_WAKE;
      end
      omc_pkg::OMC_HIBERNATE:
      begin
        s_d.bus_avail = 1'b0;
        s_d.sensor_pwr = 1'b0;
        s_d.cfg_reset = 1'b1;
        s_d.pulse_en = 1'b1;
        s_d.pulse_b = 1'b0;
        s_d.trig_sel = 1'b0;
        s_d.auto_en = 1'b0;
        s_d.sleep_cnt = `OMC_SLEEP_DELAY_RST;
        s_d.boot_done = 1'b0;
        if ((!s_q.strap && (wake_cs_i != s_q.wake_prev)) ||
            (s_q.strap && motion_wake_pin_i))
        begin
          s_d.mode = omc_pkg::OMC_BOOT;
          s_d.otp_load = 1'b1;
          s_d.mot_phase = 1'b0;
          tmr_start = 1'b1;
        end
      end
      omc_pkg::OMC_WAKE, omc_pkg::OMC_SLEEP:
      begin
        s_d.sensor_pwr = activity_i || (s_q.mode == omc_pkg::OMC_WAKE);
        if (!active_req_i && cfg_we_i && !s_q.strap)
          s_d.mode = omc_pkg::OMC_STANDBY;
        else if (s_q.strap && !motion_wake_pin_i)
          s_d.mode = omc_pkg::OMC_HIBERNATE;
        else if (activity_i)
        begin
          s_d.idle_cnt = 8'h00;
          s_d.mode = omc_pkg::OMC_WAKE;
        end
        else if (s_q.auto_ws && s_q.mode == omc_pkg::OMC_WAKE)
        begin
          if (s_q.idle_cnt >= s_q.sleep_cnt - 8'h01)
            s_d.mode = omc_pkg::OMC_SLEEP;
          else
            s_d.idle_cnt = s_q.idle_cnt + 8'h01;
        end
      end
      omc_pkg::OMC_TRIG_WAIT:
      begin
        s_d.sensor_pwr = 1'b0;
        if (!s_q.trig_sel)
          s_d.mode = omc_pkg::OMC_STANDBY;
        else if (trigger_pin_i && !s_q.trig_prev)
        begin
          s_d.mode = omc_pkg::OMC_TRIG_MEAS;
          s_d.sensor_pwr = 1'b1;
          tmr_start = 1'b1;
          tmr_len = `OMC_MEAS_CYC;
        end
      end
      omc_pkg::OMC_TRIG_MEAS:
      begin
        if (tmr_done)
        begin
          s_d.mode = omc_pkg::OMC_TRIG_WAIT;
          s_d.sensor_pwr = 1'b0;
        end
      end
    endcase
    if (!supply_good_i)
    begin
      // supply loss is a full power-off
      s_d = '0;
      s_d.mode = omc_pkg::OMC_OFF;
      s_d.pulse_en = 1'b1;
      s_d.wake_prev = wake_cs_i;
      s_d.trig_prev = trigger_pin_i;
    end
    s_d.wake_det = (s_d.mode == omc_pkg::OMC_HIBERNATE);
    s_d.bus_avail = is_active(s_d.mode) || (s_d.mode == omc_pkg::OMC_STANDBY);
    // keyed on the next state so the bus drops on the same edge that enters hibernate
    s_d.auto_ws = s_d.strap ? s_d.auto_en : (s_d.sleep_cnt != 8'h00);
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
      s_q.pulse_en <= 1'b1;
    end
    else
      s_q <= s_d;
  end
  assign auto_ws_en_o = s_q.auto_ws;
  assign mode_o = s_q.mode;
  assign bus_avail_o = s_q.bus_avail;
  assign sensor_pwr_o = s_q.sensor_pwr;
  assign wake_det_en_o = s_q.wake_det;
  assign cfg_reset_o = s_q.cfg_reset;
  assign otp_load_o = s_q.otp_load;
  assign motion_load_o = s_q.motion_load;
  assign boot_done_flag_o = s_q.boot_done;
  assign irq_out_a_o = s_q.irq_a;
  assign irq_out_b_o = s_q.irq_b;
  logic unused_busy;
  assign unused_busy = tmr_busy ^ pulse_busy;
endmodule : omc_mode_ctrl
`default_nettype wire

/* dv/omc_mode_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // inputs
  input wire logic supply_good_i,
  input wire logic boot_strap_select_i,
  input wire logic wake_cs_i,
  input wire logic motion_wake_pin_i,
  input wire logic trigger_pin_i,
  // outputs
  input wire logic [2:0] mode_o,
  input wire logic bus_avail_o,
  input wire logic irq_out_a_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic hib;
  logic hs;
  assign hib = mode_o == omc_pkg::OMC_HIBERNATE && supply_good_i;
  // strap is static, so the live pin stands in for the captured copy
  assign hs = hib && boot_strap_select_i;
  property p_off;
    !supply_good_i |=> mode_o == omc_pkg::OMC_OFF;
  endproperty
  a_off: assert property (p_off) else $error("supply low, mode not off");
  property p_bus;
    mode_o inside {omc_pkg::OMC_OFF, omc_pkg::OMC_BOOT, omc_pkg::OMC_HIBERNATE} |-> !bus_avail_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus up while off");
  property p_irqa;
    boot_strap_select_i |-> !irq_out_a_o;
  endproperty
  a_irqa: assert property (p_irqa) else $error("pulse on irq a with strap high");
  property p_lvl;
    hs && motion_wake_pin_i |=> mode_o == omc_pkg::OMC_BOOT;
  endproperty
  a_lvl: assert property (p_lvl) else $error("motion level did not boot");
  property p_stay;
    hs && !motion_wake_pin_i |=> mode_o == omc_pkg::OMC_HIBERNATE;
  endproperty
  a_stay: assert property (p_stay) else $error("left hibernate with motion low");
  property p_edge;
    hib && !boot_strap_select_i && $changed(wake_cs_i) |-> ##[1:2] mode_o == omc_pkg::OMC_BOOT;
  endproperty
  a_edge: assert property (p_edge) else $error("wake edge did not boot");
  property p_trig;
    mode_o == omc_pkg::OMC_TRIG_WAIT && $rose(trigger_pin_i) |-> ##[1:3] mode_o == omc_pkg::OMC_TRIG_MEAS;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge missed");
  property p_meas;
    $fell(mode_o == omc_pkg::OMC_TRIG_MEAS) && supply_good_i |-> mode_o == omc_pkg::OMC_TRIG_WAIT;
  endproperty
  a_meas: assert property (p_meas) else $error("measure did not return to wait");
endmodule : omc_mode_ctrl_chk
bind omc_mode_ctrl omc_mode_ctrl_chk u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .supply_good_i(supply_good_i),
  .boot_strap_select_i(boot_strap_select_i), .wake_cs_i(wake_cs_i), .motion_wake_pin_i(motion_wake_pin_i),
  .trigger_pin_i(trigger_pin_i), .mode_o(mode_o), .bus_avail_o(bus_avail_o), .irq_out_a_o(irq_out_a_o)
);
`default_nettype wire

/* dv/omc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_host_model (
  // clock and status
  input wire logic clk_sys_i,
  input wire logic bus_avail_i,
  // pins
  output logic wake_cs_o,
  output logic motion_o,
  output logic trig_o,
  // configuration writes
  output logic we_o,
  output logic act_o,
  output logic deep_o,
  output logic tsel_o,
  output logic clr_o,
  output logic [7:0] dly_o
);
  initial
  begin
    // motion pin idles high, as its pull-up would hold it
    {wake_cs_o, motion_o, trig_o, we_o, act_o, deep_o, tsel_o, clr_o} = 8'h40;
    dly_o = 8'h00;
  end
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask : tick
  // no access until boot is over; the bus is dead before
  task automatic wait_bus();
    repeat (400) if (!bus_avail_i) tick();
  endtask : wait_bus
  task automatic cfg(input logic a, input logic d, input logic t, input logic [7:0] n, input logic c);
    tick();
    {we_o, act_o, deep_o, tsel_o, clr_o} = {1'h1, a, d, t, c};
    dly_o = n;
    tick();
    {we_o, clr_o} = 2'h0;
  endtask : cfg
  task automatic wake();
    tick();
    wake_cs_o = !wake_cs_o;
  endtask : wake
  task automatic trigger();
    tick();
    trig_o = 1'h1;
    repeat (3) tick();
    trig_o = 1'h0;
  endtask : trigger
  task automatic motion(input logic v);
    tick();
    motion_o = v;
  endtask : motion
endmodule : omc_host_model
`default_nettype wire

/* dv/omc_mode_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl_tb;
  logic clk_sys_i = 1'h0;
  logic resetn_i = 1'h0;
  logic supply = 1'h1;
  logic strap = 1'h0;
  logic activity = 1'h1;
  logic auto_en = 1'h0;
  logic [2:0] last_mode = omc_pkg::OMC_OFF;
  logic [2:0] exp_q[$];
  logic [7:0] rnd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int cnt;
  integer seed = 27;
  wire logic wake_cs, motion, trig, we, act, deep, tsel, clr, bus, pwr, done, irqa, irqb, auto;
  wire logic [7:0] dly;
  wire logic [2:0] mode;
  omc_mode_ctrl u_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .supply_good_i(supply), .boot_strap_select_i(strap),
    .wake_cs_i(wake_cs), .motion_wake_pin_i(motion), .trigger_pin_i(trig), .cfg_we_i(we),
    .active_req_i(act), .deep_off_en_i(deep), .trigger_input_select_i(tsel), .auto_sleep_en_i(auto_en),
    .sleep_delay_count_i(dly), .boot_pulse_en_i(1'h1), .boot_pulse_route_b_i(1'h0), .activity_i(activity),
    .boot_done_clr_i(clr), .mode_o(mode), .bus_avail_o(bus), .sensor_pwr_o(pwr), .wake_det_en_o(),
    .cfg_reset_o(), .otp_load_o(), .motion_load_o(), .boot_done_flag_o(done), .irq_out_a_o(irqa),
    .irq_out_b_o(irqb), .auto_ws_en_o(auto)
  );
  omc_host_model u_host (
    .clk_sys_i(clk_sys_i), .bus_avail_i(bus), .wake_cs_o(wake_cs), .motion_o(motion), .trig_o(trig),
    .we_o(we), .act_o(act), .deep_o(deep), .tsel_o(tsel), .clr_o(clr), .dly_o(dly)
  );
  always #2 clk_sys_i = !clk_sys_i;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic note(input logic [2:0] m);
    exp_q.push_back(m);
  endtask : note
  // mode is polled on the falling edge, clear of the edge that launches it
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 400 && mode !== m; i++) @(negedge clk_sys_i);
    check("wait_mode", {5'h00, mode}, {5'h00, m});
    @(posedge clk_sys_i);
    #1;
  endtask : wait_mode
  // every mode change must match the oldest expected note
  always @(negedge clk_sys_i)
  begin
    cycles++;
    if (mode !== last_mode)
    begin
      last_mode = mode;
      check("mode", {5'h00, mode}, {5'h00, (exp_q.size() > 0) ? exp_q.pop_front() : 3'hx});
    end
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    rnd = 8'($random(seed)) | 8'h01;
    repeat (10) @(posedge clk_sys_i);
    #1;
    note(omc_pkg::OMC_BOOT);
    note(omc_pkg::OMC_STANDBY);
    resetn_i = 1'h1;
    u_host.wait_bus();
    wait_mode(omc_pkg::OMC_STANDBY);
    check("done", 8'(done), 8'h01);
    check("irq_a", 8'(irqa), 8'h01);
    check("irq_b", 8'(irqb), 8'h00);
    check("sense", 8'(pwr), 8'h00);
    repeat (110) @(posedge clk_sys_i);
    #1;
    check("irq_a_end", 8'(irqa), 8'h00);
    u_host.cfg(1'h0, 1'h0, 1'h0, rnd, 1'h1);
    check("done_clr", 8'(done), 8'h00);
    note(omc_pkg::OMC_WAKE);
    u_host.cfg(1'h1, 1'h0, 1'h0, rnd, 1'h0);
    wait_mode(omc_pkg::OMC_WAKE);
    check("auto", 8'(auto), 8'h01);
    check("sense_wake", 8'(pwr), 8'h01);
    note(omc_pkg::OMC_SLEEP);
    note(omc_pkg::OMC_WAKE);
    activity = 1'h0;
    for (cnt = 0; cnt < 400 && mode !== omc_pkg::OMC_SLEEP; cnt++) @(negedge clk_sys_i);
    check("sleep_delay", 8'(cnt - 1), rnd);
    @(posedge clk_sys_i);
    #1;
    activity = 1'h1;
    wait_mode(omc_pkg::OMC_WAKE);
    note(omc_pkg::OMC_STANDBY);
    note(omc_pkg::OMC_TRIG_WAIT);
    u_host.cfg(1'h0, 1'h0, 1'h0, rnd, 1'h0);
    u_host.cfg(1'h0, 1'h0, 1'h1, rnd, 1'h0);
    wait_mode(omc_pkg::OMC_TRIG_WAIT);
    for (int i = 0; i < 3; i++)
    begin
      note(omc_pkg::OMC_TRIG_MEAS);
      note(omc_pkg::OMC_TRIG_WAIT);
      u_host.trigger();
      wait_mode(omc_pkg::OMC_TRIG_MEAS);
      wait_mode(omc_pkg::OMC_TRIG_WAIT);
    end
    note(omc_pkg::OMC_STANDBY);
    note(omc_pkg::OMC_HIBERNATE);
    u_host.cfg(1'h0, 1'h0, 1'h0, rnd, 1'h0);
    u_host.cfg(1'h0, 1'h1, 1'h0, rnd, 1'h0);
    wait_mode(omc_pkg::OMC_HIBERNATE);
    check("bus_hib", 8'(bus), 8'h00);
    // a write while asleep must be ignored
    u_host.cfg(1'h1, 1'h0, 1'h0, rnd, 1'h0);
    note(omc_pkg::OMC_BOOT);
    note(omc_pkg::OMC_STANDBY);
    u_host.wake();
    u_host.wait_bus();
    check("bus_wake", 8'(bus), 8'h01);
    note(omc_pkg::OMC_OFF);
    supply = 1'h0;
    wait_mode(omc_pkg::OMC_OFF);
    check("bus_off", 8'(bus), 8'h00);
    $display("test strap low done");
    resetn_i = 1'h0;
    strap = 1'h1;
    supply = 1'h1;
    repeat (10) @(posedge clk_sys_i);
    #1;
    note(omc_pkg::OMC_BOOT);
    note(omc_pkg::OMC_WAKE);
    resetn_i = 1'h1;
    for (cnt = 0; cnt < 400 && mode !== omc_pkg::OMC_WAKE; cnt++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
    check("long_boot", 8'(cnt > 100), 8'h01);
    check("irq_b", 8'(irqb), 8'h01);
    check("auto", 8'(auto), 8'h00);
    auto_en = 1'h1;
    u_host.cfg(1'h0, 1'h0, 1'h0, rnd, 1'h0);
    check("auto_on", 8'(auto), 8'h01);
    note(omc_pkg::OMC_HIBERNATE);
    u_host.motion(1'h0);
    wait_mode(omc_pkg::OMC_HIBERNATE);
    check("bus_hib_b", 8'(bus), 8'h00);
    repeat (20) @(posedge clk_sys_i);
    note(omc_pkg::OMC_BOOT);
    note(omc_pkg::OMC_WAKE);
    u_host.motion(1'h1);
    wait_mode(omc_pkg::OMC_WAKE);
    check("queue", 8'(exp_q.size()), 8'h00);
    $display("test strap high done");
    finish_test();
  end
endmodule : omc_mode_ctrl_tb
`default_nettype wire
